// ===== logic/input_capture_cascade.sv
/*
  One odd/even pair of input capture units with private 16-bit counters,
  4-entry capture FIFOs and optional 32-bit chaining.
  Assumes time base ticks, sync events and enables come from logic on
  clk_sys; the two capture inputs are pins and are synchronised here.
*/
`timescale 1ns/1ps
module input_capture_cascade #(
  parameter int FifoDepth = 4,
  parameter int NumTimebase = 8,
  parameter int NumSync = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic captureInputOdd,
  input wire logic captureInputEven,
  input wire logic [NumTimebase-1:0] timebaseTick,
  input wire logic [NumTimebase-1:0] timebaseEnable,
  input wire logic [NumSync-1:0] syncEvent,
  input wire logic [NumSync-1:0] syncEnable,
  input wire logic cpuIdle,
  output logic [1:0] captureIrq
);

  localparam int PtrW = (FifoDepth > 1) ? $clog2(FifoDepth) : 1;
  localparam int CntW = $clog2(FifoDepth + 1);
  localparam logic [CntW-1:0] FullCount = CntW'(FifoDepth);
  localparam logic [PtrW-1:0] LastPtr = PtrW'(FifoDepth - 1);

  // ----------------------------------------------------------------------
  // Shared state of both units (index 0 odd, index 1 even)
  // ----------------------------------------------------------------------
  logic [15:0] ctlOne_ff [2];
  logic [15:0] ctlTwo_ff [2];
  logic [15:0] counter_ff [2];
  logic [15:0] fifoHead [2];
  logic [CntW-1:0] fifoCount_ff [2];
  logic overflow_ff [2];
  logic [1:0] pinMeta_ff;
  logic [1:0] pinSync_ff;
  logic [1:0] pinPrev_ff;
  logic [1:0] wrapPulse;
  logic [1:0] capEvent;
  logic [1:0] gateOn;
  logic cascadeOn;

  // Pins are asynchronous; only the second and third stages are looked at
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinMeta_ff <= 2'h0;
      pinSync_ff <= 2'h0;
      pinPrev_ff <= 2'h0;
    end else begin
      pinMeta_ff <= {captureInputEven, captureInputOdd};
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  assign cascadeOn = ctlTwo_ff[0][input_capture_cascade_pkg::CascadeBit] &
                     ctlTwo_ff[1][input_capture_cascade_pkg::CascadeBit];

  // ----------------------------------------------------------------------
  // Per unit logic
  // ----------------------------------------------------------------------
  for (genvar gi = 0; gi < 2; gi++) begin : g_unit
    localparam logic [2:0] AddrOne = (gi == 0) ? input_capture_cascade_pkg::RegCtlOneOdd :
                                                 input_capture_cascade_pkg::RegCtlOneEven;
    localparam logic [2:0] AddrTwo = (gi == 0) ? input_capture_cascade_pkg::RegCtlTwoOdd :
                                                 input_capture_cascade_pkg::RegCtlTwoEven;
    localparam logic [2:0] AddrBuf = (gi == 0) ? input_capture_cascade_pkg::RegBufLow :
                                                 input_capture_cascade_pkg::RegBufHigh;
    logic follower;
    logic [2:0] mode;
    logic [1:0] capPerIrq;
    logic trigMode;
    logic trigStatus;
    logic [4:0] sync_source_select;
    logic [2:0] tbSel;
    logic enabled;
    logic syncMode;
    logic holdReset;
    logic running;
    logic tick;
    logic syncHit;
    logic rise;
    logic fall;
    logic candidate;
    logic pop;
    logic push;
    logic [3:0] prescale_ff;
    logic [1:0] irqCount_ff;
    logic irq_ff;
    logic [15:0] mem_ff [FifoDepth];
    logic [PtrW-1:0] wrPtr_ff;
    logic [PtrW-1:0] rdPtr_ff;

    // A chained even unit takes its mode, interrupt pacing and trigger settings from the odd unit
    assign follower = (gi == 1) && cascadeOn;
    assign mode = follower ? ctlOne_ff[0][2:0] : ctlOne_ff[gi][2:0];
    assign capPerIrq = follower ? ctlOne_ff[0][6:5] : ctlOne_ff[gi][6:5];
    assign trigMode = follower ? ctlTwo_ff[0][input_capture_cascade_pkg::TrigModeBit] :
                                 ctlTwo_ff[gi][input_capture_cascade_pkg::TrigModeBit];
    assign trigStatus = follower ? ctlTwo_ff[0][input_capture_cascade_pkg::TrigStatusBit] :
                                   ctlTwo_ff[gi][input_capture_cascade_pkg::TrigStatusBit];
    assign sync_source_select = ctlTwo_ff[gi][4:0];
    assign tbSel = ctlOne_ff[gi][12:10];

    assign enabled = (mode != input_capture_cascade_pkg::ModeOff) &&
                     (mode != input_capture_cascade_pkg::ModeUnused) &&
                     !(cpuIdle && ctlOne_ff[gi][input_capture_cascade_pkg::IdleHaltBit]);
    assign syncMode = (sync_source_select != input_capture_cascade_pkg::SyncSelNone) && !trigMode;
    assign holdReset = syncMode && !syncEnable[sync_source_select];
    assign syncHit = (sync_source_select != input_capture_cascade_pkg::SyncSelNone) && syncEvent[sync_source_select];
    // Trigger modes (hardware or software) run only while the status bit is set
    assign running = trigMode ? trigStatus : 1'b1;
    assign gateOn[gi] = enabled && timebaseEnable[tbSel] && running && !holdReset;
    // Chained even counter advances only on the odd wrap
    assign tick = follower ? (wrapPulse[0] && gateOn[gi]) : (gateOn[gi] && timebaseTick[tbSel]);
    assign wrapPulse[gi] = tick && (counter_ff[gi] == input_capture_cascade_pkg::CounterMax);

    always_ff @(posedge clk_sys) begin
      if (reset || holdReset || !enabled) begin
        counter_ff[gi] <= 16'h0000;
      end else if (syncMode && syncHit) begin
        counter_ff[gi] <= 16'h0000;
      end else if (tick) begin
        counter_ff[gi] <= counter_ff[gi] + 16'h0001;
      end
    end

    // Control registers; hardware trigger set wins over a software clear
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        ctlOne_ff[gi] <= input_capture_cascade_pkg::CtlOneReset;
        ctlTwo_ff[gi] <= input_capture_cascade_pkg::CtlTwoReset;
      end else begin
        if (regWrite && regAddr == AddrOne) begin
          ctlOne_ff[gi] <= regWrData & input_capture_cascade_pkg::CtlOneWriteMask;
        end
        if (regWrite && regAddr == AddrTwo) begin
          ctlTwo_ff[gi] <= regWrData & input_capture_cascade_pkg::CtlTwoWriteMask;
        end
        if (ctlTwo_ff[gi][input_capture_cascade_pkg::TrigModeBit] && syncHit && enabled) begin
          ctlTwo_ff[gi][input_capture_cascade_pkg::TrigStatusBit] <= 1'b1;
        end
      end
    end

    assign rise = pinSync_ff[gi] && !pinPrev_ff[gi];
    assign fall = !pinSync_ff[gi] && pinPrev_ff[gi];

    always_comb begin
      candidate = 1'b0;
      case (mode)
        input_capture_cascade_pkg::ModeEveryEdge: candidate = rise || fall;
        input_capture_cascade_pkg::ModeFalling: candidate = fall;
        input_capture_cascade_pkg::ModeRising: candidate = rise;
        input_capture_cascade_pkg::ModeWake: candidate = rise;
        input_capture_cascade_pkg::ModeRiseDiv4:
          candidate = rise && (prescale_ff == input_capture_cascade_pkg::PrescaleLast4);
        input_capture_cascade_pkg::ModeRiseDiv16:
          candidate = rise && (prescale_ff == input_capture_cascade_pkg::PrescaleLast16);
        default: candidate = 1'b0;
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (reset || !gateOn[gi]) begin
        prescale_ff <= 4'h0;
      end else if (rise && candidate) begin
        prescale_ff <= 4'h0;
      end else if (rise) begin
        prescale_ff <= prescale_ff + 4'h1;
      end
    end

    // Chained even unit captures on the odd unit's event, same cycle
    assign capEvent[gi] = follower ? capEvent[0] : (gateOn[gi] && candidate);

    assign pop = regRead && (regAddr == AddrBuf) && (fifoCount_ff[gi] != '0);
    assign push = capEvent[gi] && (fifoCount_ff[gi] != FullCount);

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        wrPtr_ff <= '0;
        rdPtr_ff <= '0;
        fifoCount_ff[gi] <= '0;
      end else begin
        if (push) begin
          mem_ff[wrPtr_ff] <= counter_ff[gi];
          wrPtr_ff <= (wrPtr_ff == LastPtr) ? '0 : wrPtr_ff + PtrW'(1);
        end
        if (pop) begin
          rdPtr_ff <= (rdPtr_ff == LastPtr) ? '0 : rdPtr_ff + PtrW'(1);
        end
        if (push && !pop) begin
          fifoCount_ff[gi] <= fifoCount_ff[gi] + CntW'(1);
        end else if (pop && !push) begin
          fifoCount_ff[gi] <= fifoCount_ff[gi] - CntW'(1);
        end
      end
    end
    assign fifoHead[gi] = mem_ff[rdPtr_ff];

    // Overflow is read-only; it clears when the unit is switched off
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        overflow_ff[gi] <= 1'b0;
      end else if (capEvent[gi] && fifoCount_ff[gi] == FullCount) begin
        overflow_ff[gi] <= 1'b1;
      end else if (mode == input_capture_cascade_pkg::ModeOff) begin
        overflow_ff[gi] <= 1'b0;
      end
    end

    // Interrupt pacing counts captures, not edges; chained even stays quiet
    always_ff @(posedge clk_sys) begin
      if (reset || !gateOn[gi]) begin
        irqCount_ff <= 2'h0;
        irq_ff <= 1'b0;
      end else if (capEvent[gi] && !follower) begin
        if (irqCount_ff == capPerIrq || mode == input_capture_cascade_pkg::ModeEveryEdge) begin
          irqCount_ff <= 2'h0;
          irq_ff <= 1'b1;
        end else begin
          irqCount_ff <= irqCount_ff + 2'h1;
          irq_ff <= 1'b0;
        end
      end else begin
        irq_ff <= 1'b0;
      end
    end
    assign captureIrq[gi] = irq_ff;
  end

  // ----------------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------------------------------------
  function automatic logic [15:0] ctlOneView(input logic [15:0] ctl,
                                            input logic ovf,
                                            input logic notEmpty);
    logic [15:0] view;
    view = ctl;
    view[input_capture_cascade_pkg::OverflowBit] = ovf;
    view[input_capture_cascade_pkg::NotEmptyBit] = notEmpty;
    return view;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        input_capture_cascade_pkg::RegCtlOneOdd:
          regRdData <= ctlOneView(ctlOne_ff[0], overflow_ff[0], fifoCount_ff[0] != '0);
        input_capture_cascade_pkg::RegCtlTwoOdd: regRdData <= ctlTwo_ff[0];
        input_capture_cascade_pkg::RegBufLow: regRdData <= fifoHead[0];
        input_capture_cascade_pkg::RegCtlOneEven:
          regRdData <= ctlOneView(ctlOne_ff[1], overflow_ff[1], fifoCount_ff[1] != '0);
        input_capture_cascade_pkg::RegCtlTwoEven: regRdData <= ctlTwo_ff[1];
        input_capture_cascade_pkg::RegBufHigh: regRdData <= fifoHead[1];
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

endmodule // input_capture_cascade

// ===== logic/input_capture_cascade_pkg.sv
/*
  Constants shared by the input capture pair: register indices, field
  positions, writable masks, mode codes and prescale counts.
  Assumes a 16-bit register port addressed by register index.
*/
package input_capture_cascade_pkg;

  // ----------------------------------------------------------------------
  // Register indices (register port address)
  // ----------------------------------------------------------------------
  localparam int AddrWidth = 3;
  localparam int DataWidth = 16;
  localparam logic [2:0] RegCtlOneOdd = 3'h0;
  localparam logic [2:0] RegCtlTwoOdd = 3'h1;
  localparam logic [2:0] RegBufLow = 3'h2;
  localparam logic [2:0] RegCtlOneEven = 3'h3;
  localparam logic [2:0] RegCtlTwoEven = 3'h4;
  localparam logic [2:0] RegBufHigh = 3'h5;

  // ----------------------------------------------------------------------
  // Field positions of capture_control_one
  // ----------------------------------------------------------------------
  localparam int IdleHaltBit = 13;
  localparam int TimebaseSelLsb = 10;
  localparam int CapPerIrqLsb = 5;
  localparam int OverflowBit = 4;
  localparam int NotEmptyBit = 3;
  localparam int ModeLsb = 0;
  localparam logic [15:0] CtlOneWriteMask = 16'h3c67;
  localparam logic [15:0] CtlOneReset = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions of capture_control_two
  // ----------------------------------------------------------------------
  localparam int CascadeBit = 8;
  localparam int TrigModeBit = 7;
  localparam int TrigStatusBit = 6;
  localparam int SyncSelLsb = 0;
  localparam logic [15:0] CtlTwoWriteMask = 16'h01df;
  localparam logic [15:0] CtlTwoReset = 16'h0000;
  localparam logic [4:0] SyncSelNone = 5'h00;

  // ----------------------------------------------------------------------
  // Capture modes and prescale counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] ModeOff = 3'h0;
  localparam logic [2:0] ModeEveryEdge = 3'h1;
  localparam logic [2:0] ModeFalling = 3'h2;
  localparam logic [2:0] ModeRising = 3'h3;
  localparam logic [2:0] ModeRiseDiv4 = 3'h4;
  localparam logic [2:0] ModeRiseDiv16 = 3'h5;
  localparam logic [2:0] ModeUnused = 3'h6;
  localparam logic [2:0] ModeWake = 3'h7;
  localparam logic [3:0] PrescaleLast4 = 4'h3;
  localparam logic [3:0] PrescaleLast16 = 4'hf;
  localparam logic [15:0] CounterMax = 16'hffff;

endpackage

// ===== bench/input_capture_cascade_chk.sv
/*
  Port-level checker for the input capture pair, bound to its top module.
  Assumes one clock domain, synchronous active-high reset.
*/
`timescale 1ns/1ps
module input_capture_cascade_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic captureInputOdd,
  input wire logic captureInputEven,
  input wire logic [1:0] captureIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // Cycles since each pin last moved; an interrupt needs a recent edge
  // ----------------------------------------------------------------------
  logic oddPin_ff, evenPin_ff;
  logic [7:0] sinceOdd_ff, sinceEven_ff;
  always_ff @(posedge clk_sys) begin
    oddPin_ff <= captureInputOdd;
    evenPin_ff <= captureInputEven;
    if (reset) begin
      sinceOdd_ff <= 8'hff;
      sinceEven_ff <= 8'hff;
    end else begin
      sinceOdd_ff <= (captureInputOdd != oddPin_ff) ? 8'h00 : sinceOdd_ff + 8'(sinceOdd_ff != 8'hff);
      sinceEven_ff <= (captureInputEven != evenPin_ff) ? 8'h00 :
        sinceEven_ff + 8'(sinceEven_ff != 8'hff);
    end
  end
  AST_RD_ZERO: assert property (!$past(regRead) |-> regRdData == 16'h0000)
    else $error("read data not zero outside read slot");
  AST_RD_UNMAPPED: assert property (regRead && regAddr > 3'h5 |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> captureIrq == 2'h0)
    else $error("interrupt during reset");
  AST_CTL1_RB: assert property (regWrite && regAddr == 3'h0 ##1 !regWrite ##1 regRead && regAddr == 3'h0
    |=> (regRdData & 16'h3c67) == ($past(regWrData, 3) & 16'h3c67) && regRdData[9:7] == 3'h0)
    else $error("control one readback wrong");
  AST_CTL2_RB: assert property (regWrite && regAddr == 3'h4 && regWrData[4:0] == 5'h00 ##1 !regWrite
    ##1 regRead && regAddr == 3'h4 |=> regRdData == ($past(regWrData, 3) & 16'h01df))
    else $error("control two readback wrong");
  AST_CTL2_RSVD: assert property (regRead && (regAddr == 3'h1 || regAddr == 3'h4)
    |=> regRdData[15:9] == 7'h00 && !regRdData[5])
    else $error("reserved control two bits set");
  AST_IRQ_ODD: assert property (captureIrq[0] |-> sinceOdd_ff inside {[8'h02:8'h08]})
    else $error("odd interrupt without pin edge");
  AST_IRQ_EVEN: assert property (captureIrq[1] |-> sinceEven_ff inside {[8'h02:8'h08]})
    else $error("even interrupt without pin edge");
endmodule // input_capture_cascade_chk

bind input_capture_cascade input_capture_cascade_chk u_chk (.clk_sys, .reset, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .captureInputOdd, .captureInputEven, .captureIrq);

// ===== bench/capture_source_model.sv
/*
  Far side of the capture pair: the two capture pins and the time bases.
  Assumes the pair samples the pins on clk_sys.
*/
`timescale 1ns/1ps
module capture_source_model (
  input wire logic clk_sys,
  output logic captureInputOdd,
  output logic captureInputEven,
  output logic [7:0] timebaseTick,
  output logic [7:0] timebaseEnable
);
  // Every source ticks each cycle, so captured counts equal elapsed cycles
  initial begin
    captureInputOdd = 1'b0;
    captureInputEven = 1'b0;
    timebaseTick = 8'hff;
    timebaseEnable = 8'hff;
  end
  // Square pulses with rising edges exactly per cycles apart
  task automatic pulse(input bit even, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (even) captureInputEven <= 1'b1;
      else captureInputOdd <= 1'b1;
      repeat (per / 2) @(posedge clk_sys);
      if (even) captureInputEven <= 1'b0;
      else captureInputOdd <= 1'b0;
      repeat (per / 2 - 1) @(posedge clk_sys);
    end
  endtask
endmodule // capture_source_model

// ===== bench/input_capture_cascade_test.sv
/*
  Register-driven testbench for the input capture pair.
  Assumes capture_source_model drives pins and time bases.
*/
`timescale 1ns/1ps
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin failCount++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module input_capture_cascade_test;
  logic clk_sys, reset, regWrite, regRead, cpuIdle;
  logic [2:0] regAddr;
  logic [15:0] regWrData, d, a, b, c, e;
  wire logic [15:0] regRdData;
  logic [31:0] syncEnable, syncEvent;
  wire logic [1:0] captureIrq;
  wire logic capOdd, capEven;
  wire logic [7:0] tbTick, tbEn;
  int failCount = 0, checksDone = 0, irqOdd = 0, irqEven = 0;
  // Table: control one, control two, idle, sync on, expected interrupts
  logic [15:0] c1[12] = '{16'h2001, 16'h2003, 16'h2004, 16'h2005, 16'h2023, 16'h2043,
    16'h2063, 16'h2003, 16'h2003, 16'h2003, 16'h2003, 16'h2003};
  logic [15:0] c2[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 16'h0080, 16'h00c0, 16'h0001, 16'h0001};
  bit idl[12] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0};
  bit syn[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1};
  int ex[12] = '{32, 16, 4, 1, 8, 5, 4, 0, 0, 16, 0, 16};
  input_capture_cascade u_dut (.clk_sys, .reset, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .captureInputOdd(capOdd), .captureInputEven(capEven), .timebaseTick(tbTick),
    .timebaseEnable(tbEn), .syncEvent, .syncEnable, .cpuIdle, .captureIrq);
  capture_source_model u_src (.clk_sys, .captureInputOdd(capOdd), .captureInputEven(capEven),
    .timebaseTick(tbTick), .timebaseEnable(tbEn));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    irqOdd += int'(captureIrq[0] === 1'b1);
    irqEven += int'(captureIrq[1] === 1'b1);
  end
  task automatic wr(input logic [2:0] ad, input logic [15:0] v);
    @(posedge clk_sys);
    regAddr <= ad;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] ad, output logic [15:0] v);
    @(posedge clk_sys);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic completeRun;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    // The cascade wait dominates: about 66000 cycles of a 71000 cycle run
    repeat (90000) @(posedge clk_sys);
    failCount++;
    completeRun;
  end
  initial begin
    reset = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 3'h0; regWrData = 16'h0;
    cpuIdle = 1'b0; syncEnable = 32'h0; syncEvent = 32'h0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (c1[k]) if (k < 8 && k != 2 && k != 5) begin
      rd(3'(k), d);
      `CHECK(d, 16'h0000)
    end
    wr(3'h0, 16'hffff);
    rd(3'h0, d);
    `CHECK(d, 16'h3c67)
    wr(3'h1, 16'hffff);
    rd(3'h1, d);
    `CHECK(d, 16'h01df)
    wr(3'h1, 16'h0);
    wr(3'h0, 16'h0);
    $display("registers done");
    foreach (c1[k]) begin
      wr(3'h1, c2[k]);
      wr(3'h0, c1[k]);
      cpuIdle <= idl[k];
      syncEnable <= syn[k] ? 32'h2 : 32'h0;
      for (int i = 0; i < 16; i++) begin
        u_src.pulse(0, 1, 20);
        rd(3'h2, d);
        rd(3'h2, d);
      end
      repeat (10) @(posedge clk_sys);
      `CHECK(irqOdd, ex[k])
      `CHECK(irqEven, 0)
      rd(3'h0, d);
      `CHECK(d[3], 1'b0)
      wr(3'h0, 16'h0);
      cpuIdle <= 1'b0;
      #1 irqOdd = 0;
      $display("mode entry %0d done", k);
    end
    wr(3'h0, 16'h0003);
    u_src.pulse(0, 5, 20);
    repeat (10) @(posedge clk_sys);
    rd(3'h0, d);
    `CHECK(d[4:3], 2'b11)
    rd(3'h2, a);
    for (int i = 0; i < 3; i++) begin
      rd(3'h2, b);
      `CHECK(b - a, 16'h0014)
      a = b;
    end
    rd(3'h0, d);
    `CHECK(d[4:3], 2'b10)
    wr(3'h0, 16'h0);
    rd(3'h0, d);
    `CHECK(d[4], 1'b0)
    $display("fifo done");
    wr(3'h1, 16'h0081);
    wr(3'h0, 16'h0003);
    @(posedge clk_sys);
    syncEvent <= 32'h00000002;
    @(posedge clk_sys);
    syncEvent <= 32'h00000000;
    rd(3'h1, d);
    `CHECK(d, 16'h00c1)
    u_src.pulse(0, 1, 20);
    rd(3'h0, d);
    `CHECK(d[3], 1'b1)
    rd(3'h2, d);
    wr(3'h0, 16'h0000);
    $display("trigger done");
    wr(3'h3, 16'h0003);
    #1 irqEven = 0;
    u_src.pulse(1, 3, 20);
    repeat (10) @(posedge clk_sys);
    `CHECK(irqEven, 3)
    rd(3'h5, a);
    rd(3'h5, b);
    `CHECK(b - a, 16'h0014)
    rd(3'h5, b);
    rd(3'h3, d);
    `CHECK(d[3], 1'b0)
    wr(3'h3, 16'h0000);
    $display("even unit done");
    wr(3'h1, 16'h0100);
    wr(3'h0, 16'h0003);
    u_src.pulse(0, 1, 20);
    rd(3'h3, d);
    `CHECK(d[3], 1'b0)
    rd(3'h2, d);
    wr(3'h0, 16'h0);
    wr(3'h4, 16'h0100);
    rd(3'h4, d);
    `CHECK(d, 16'h0100)
    wr(3'h1, 16'h0100);
    wr(3'h3, 16'h0);
    wr(3'h0, 16'h0003);
    #1 irqOdd = 0;
    irqEven = 0;
    // Run the low half up near its wrap so the two captures straddle it
    repeat (65480) @(posedge clk_sys);
    u_src.pulse(0, 2, 100);
    repeat (10) @(posedge clk_sys);
    rd(3'h0, d);
    `CHECK(d[3], 1'b1)
    rd(3'h2, a);
    rd(3'h5, b);
    rd(3'h2, c);
    rd(3'h5, e);
    `CHECK({e, c} - {b, a}, 32'h00000064)
    `CHECK(e - b, 16'h0001)
    `CHECK(irqOdd, 2)
    `CHECK(irqEven, 0)
    $display("cascade done");
    completeRun;
  end
endmodule // input_capture_cascade_test
